// *** hw/bbi_input.sv ***
// baseband sample input stage: serial port, holding registers, first slot
//
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
module bbi_input #(
  parameter int WORD_W = 16,
  parameter int SLOT_W = 10
) (
  // clock and reset
  input  wire logic              i_ref_clk,
  input  wire logic              i_rst,
  // register port
  input  wire logic [6:0]        i_addr,
  input  wire logic [15:0]       i_wr_data,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic [15:0]            o_rd_data,
  // timing and enable
  input  wire logic              i_sample_start,
  input  wire logic              i_transmit_enable_pin,
  // serial link
  input  wire logic [3:0]        i_ser_data,
  output logic                   o_sclk,
  output logic                   o_frame,
  // fifo write side
  output logic                   o_push,
  output logic [WORD_W-1:0]      o_push_i,
  output logic [WORD_W-1:0]      o_push_q,
  // shaping filter side
  input  wire logic              i_filt_req,
  output logic                   o_filt_valid,
  output logic [WORD_W-1:0]      o_filt_i,
  output logic [WORD_W-1:0]      o_filt_q
);
  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  logic [15:0]       main_ctl;
  logic [15:0]       ser_ctl;
  logic [15:0]       ser_aux;
  logic [SLOT_W-1:0] i_slot;
  logic [SLOT_W-1:0] q_slot;
  logic [WORD_W-1:0] hold_q;
  logic [15:0]       next_main_ctl;
  logic [15:0]       next_ser_ctl;
  logic [15:0]       next_ser_aux;
  logic [SLOT_W-1:0] next_i_slot;
  logic [SLOT_W-1:0] next_q_slot;
  logic [WORD_W-1:0] next_hold_q;
  logic [15:0]       next_rd_data;
  logic              serial_mode;
  logic              tx_en;
  logic [5:0]        sclk_sel;
  logic              b2b_ok;

  assign serial_mode = ser_ctl[bbi_pkg::SER_MODE_BIT];
  assign sclk_sel    = ser_ctl[bbi_pkg::SER_CLK_LSB +: 6];
  assign tx_en       = i_transmit_enable_pin
                       | main_ctl[bbi_pkg::MAIN_SW_TXEN];
  assign b2b_ok      = (sclk_sel == bbi_pkg::SCLK_32X)
                       && (&ser_aux[bbi_pkg::AUX_B2B_LSB +: 2]);

  // -----------------------------------------------------------------
  // first fifo location and filter feed
  // -----------------------------------------------------------------
  logic              par_push;
  logic              ser_push;
  logic [WORD_W-1:0] i_word;
  logic [WORD_W-1:0] q_word;
  logic              loc_valid;
  logic [WORD_W-1:0] loc_i;
  logic [WORD_W-1:0] loc_q;
  logic              next_loc_valid;
  logic [WORD_W-1:0] next_loc_i;
  logic [WORD_W-1:0] next_loc_q;
  logic              next_push;
  logic [WORD_W-1:0] next_push_i;
  logic [WORD_W-1:0] next_push_q;
  logic              next_filt_valid;
  logic [WORD_W-1:0] next_filt_i;
  logic [WORD_W-1:0] next_filt_q;

  assign par_push = i_wr && (i_addr == bbi_pkg::ADDR_I_DATA)
                    && !serial_mode;

  always_comb begin
    next_main_ctl = main_ctl;
    next_ser_ctl  = ser_ctl;
    next_ser_aux  = ser_aux;
    next_i_slot   = i_slot;
    next_q_slot   = q_slot;
    next_hold_q   = hold_q;
    next_rd_data  = 16'h0000;
    if (i_wr) begin
      if (i_addr == bbi_pkg::ADDR_Q_DATA) begin
        next_hold_q = i_wr_data;
      end else if (i_addr == bbi_pkg::ADDR_MAIN_CTL) begin
        next_main_ctl = i_wr_data;
      end else if (i_addr == bbi_pkg::ADDR_SER_CTL) begin
        next_ser_ctl = i_wr_data;
      end else if (i_addr == bbi_pkg::ADDR_I_SLOT) begin
        next_i_slot = i_wr_data[SLOT_W-1:0];
      end else if (i_addr == bbi_pkg::ADDR_Q_SLOT) begin
        next_q_slot = i_wr_data[SLOT_W-1:0];
      end else if (i_addr == bbi_pkg::ADDR_SER_AUX) begin
        next_ser_aux = i_wr_data;
      end
    end
    if (i_rd) begin
      if (i_addr == bbi_pkg::ADDR_I_DATA) begin
        next_rd_data = loc_i;
      end else if (i_addr == bbi_pkg::ADDR_Q_DATA) begin
        next_rd_data = loc_q;
      end else if (i_addr == bbi_pkg::ADDR_MAIN_CTL) begin
        next_rd_data = main_ctl;
      end else if (i_addr == bbi_pkg::ADDR_SER_CTL) begin
        next_rd_data = ser_ctl;
      end else if (i_addr == bbi_pkg::ADDR_I_SLOT) begin
        next_rd_data = 16'(i_slot);
      end else if (i_addr == bbi_pkg::ADDR_Q_SLOT) begin
        next_rd_data = 16'(q_slot);
      end else if (i_addr == bbi_pkg::ADDR_SER_AUX) begin
        next_rd_data = ser_aux;
      end
    end
  end

  always_comb begin
    next_push       = 1'b0;
    next_push_i     = o_push_i;
    next_push_q     = o_push_q;
    next_loc_valid  = loc_valid;
    next_loc_i      = loc_i;
    next_loc_q      = loc_q;
    next_filt_valid = 1'b0;
    next_filt_i     = o_filt_i;
    next_filt_q     = o_filt_q;
    if (i_filt_req) begin
      next_filt_valid = 1'b1;
      // an empty location feeds zeros rather than stale data
      next_filt_i     = loc_valid ? loc_i : '0;
      next_filt_q     = loc_valid ? loc_q : '0;
      next_loc_valid  = 1'b0;
    end
    // a push in the drain cycle wins, so no pair is lost
    if (par_push) begin
      next_push      = 1'b1;
      next_push_i    = i_wr_data;
      next_push_q    = hold_q;
      next_loc_valid = 1'b1;
      next_loc_i     = i_wr_data;
      next_loc_q     = hold_q;
    end else if (ser_push) begin
      next_push      = 1'b1;
      next_push_i    = i_word;
      next_push_q    = q_word;
      next_loc_valid = 1'b1;
      next_loc_i     = i_word;
      next_loc_q     = q_word;
    end
  end

  // -----------------------------------------------------------------
  // serial clock divider
  // -----------------------------------------------------------------
  logic [15:0] div_cnt;
  logic [15:0] samp_cnt;
  logic [15:0] samp_per;
  logic [15:0] period;
  logic [15:0] x32_per;
  logic        tick;
  logic [15:0] next_div_cnt;
  logic [15:0] next_samp_cnt;
  logic [15:0] next_samp_per;
  logic        next_sclk;

  always_comb begin
    x32_per = samp_per >> bbi_pkg::X32_SHIFT;
    if (sclk_sel == bbi_pkg::SCLK_MASTER) begin
      period = bbi_pkg::MIN_SCLK_PER;
    end else if (sclk_sel == bbi_pkg::SCLK_32X) begin
      period = (x32_per < bbi_pkg::MIN_SCLK_PER) ?
               bbi_pkg::MIN_SCLK_PER : x32_per;
    end else begin
      period = {9'h000, sclk_sel, 1'b0};
    end
    tick          = (div_cnt >= period - 16'h0001);
    next_div_cnt  = tick ? 16'h0000 : div_cnt + 16'h0001;
    next_sclk     = (next_div_cnt < (period >> 1));
    next_samp_cnt = i_sample_start ? 16'h0000 : samp_cnt + 16'h0001;
    next_samp_per = i_sample_start ? samp_cnt + 16'h0001 : samp_per;
  end

  // -----------------------------------------------------------------
  // frame sequencing
  // -----------------------------------------------------------------
  logic pend;
  logic busy;
  logic i_got;
  logic q_got;
  logic i_done;
  logic q_done;
  logic start;
  logic ser_bit;
  logic next_pend;
  logic next_busy;
  logic next_frame;
  logic next_i_got;
  logic next_q_got;
  logic run_ok;

  assign ser_bit = i_ser_data[ser_ctl[bbi_pkg::SER_PORT_LSB +: 2]];
  assign run_ok  = tx_en || main_ctl[bbi_pkg::MAIN_TXEN_INDEP];
  assign start   = tick && pend;
  assign ser_push = serial_mode && (i_got || i_done) && (q_got || q_done)
                    && busy;

  always_comb begin
    next_pend  = pend;
    next_busy  = busy;
    next_frame = o_frame;
    next_i_got = i_got | i_done;
    next_q_got = q_got | q_done;
    if (i_sample_start && serial_mode && run_ok && (!busy || b2b_ok)) begin
      next_pend = 1'b1;
    end
    if (tick) begin
      next_frame = 1'b0;
    end
    if (start) begin
      next_pend  = 1'b0;
      next_busy  = 1'b1;
      next_frame = tx_en;
      next_i_got = 1'b0;
      next_q_got = 1'b0;
    end else if (ser_push) begin
      next_busy  = 1'b0;
      next_i_got = 1'b0;
      next_q_got = 1'b0;
    end
    if (!serial_mode) begin
      next_pend = 1'b0;
      next_busy = 1'b0;
    end
  end

  bbi_slot #(.SLOT_W(SLOT_W), .WORD_W(WORD_W)) u_slot_i (
    .i_ref_clk  (i_ref_clk),
    .i_rst      (i_rst),
    .i_tick     (tick),
    .i_start    (start),
    .i_slot     (i_slot),
    .i_len_code (ser_ctl[bbi_pkg::SER_LEN_LSB +: 2]),
    .i_bit      (ser_bit),
    .o_done     (i_done),
    .o_word     (i_word)
  );

  bbi_slot #(.SLOT_W(SLOT_W), .WORD_W(WORD_W)) u_slot_q (
    .i_ref_clk  (i_ref_clk),
    .i_rst      (i_rst),
    .i_tick     (tick),
    .i_start    (start),
    .i_slot     (q_slot),
    .i_len_code (ser_ctl[bbi_pkg::SER_LEN_LSB +: 2]),
    .i_bit      (ser_bit),
    .o_done     (q_done),
    .o_word     (q_word)
  );

  // -----------------------------------------------------------------
  // state registers
  // -----------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      main_ctl     <= bbi_pkg::CTL_RESET;
      ser_ctl      <= bbi_pkg::CTL_RESET;
      ser_aux      <= bbi_pkg::CTL_RESET;
      i_slot       <= bbi_pkg::SLOT_RESET;
      q_slot       <= bbi_pkg::SLOT_RESET;
      hold_q       <= '0;
      o_rd_data    <= 16'h0000;
      o_push       <= 1'b0;
      o_push_i     <= '0;
      o_push_q     <= '0;
      loc_valid    <= 1'b0;
      loc_i        <= '0;
      loc_q        <= '0;
      o_filt_valid <= 1'b0;
      o_filt_i     <= '0;
      o_filt_q     <= '0;
      div_cnt      <= 16'h0000;
      samp_cnt     <= 16'h0000;
      samp_per     <= 16'h0000;
      o_sclk       <= 1'b0;
      pend         <= 1'b0;
      busy         <= 1'b0;
      o_frame      <= 1'b0;
      i_got        <= 1'b0;
      q_got        <= 1'b0;
    end else begin
      main_ctl     <= next_main_ctl;
      ser_ctl      <= next_ser_ctl;
      ser_aux      <= next_ser_aux;
      i_slot       <= next_i_slot;
      q_slot       <= next_q_slot;
      hold_q       <= next_hold_q;
      o_rd_data    <= next_rd_data;
      o_push       <= next_push;
      o_push_i     <= next_push_i;
      o_push_q     <= next_push_q;
      loc_valid    <= next_loc_valid;
      loc_i        <= next_loc_i;
      loc_q        <= next_loc_q;
      o_filt_valid <= next_filt_valid;
      o_filt_i     <= next_filt_i;
      o_filt_q     <= next_filt_q;
      div_cnt      <= next_div_cnt;
      samp_cnt     <= next_samp_cnt;
      samp_per     <= next_samp_per;
      o_sclk       <= next_sclk;
      pend         <= next_pend;
      busy         <= next_busy;
      o_frame      <= next_frame;
      i_got        <= next_i_got;
      q_got        <= next_q_got;
    end
  end

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  a_serial_mode_sel: assert property (
    o_push && $past(!par_push) |-> $past(serial_mode))
    else $error("serial push outside serial mode");
  a_par_push_pair: assert property (
    par_push |=> o_push && o_push_i == $past(i_wr_data)
                 && o_push_q == $past(hold_q))
    else $error("holding pair not pushed on word 0 write");
  a_par_blocked: assert property (
    (i_wr && i_addr == bbi_pkg::ADDR_I_DATA && serial_mode && !ser_push)
    |=> !o_push)
    else $error("parallel write pushed in serial mode");
  a_frame_on_tick: assert property (
    $rose(o_frame) |-> $past(tick && pend))
    else $error("frame strobe not aligned to serial clock");
  a_frame_txen: assert property (
    $rose(o_frame) |-> $past(tx_en))
    else $error("frame strobe without transmit enable");
  a_frame_ends: assert property (
    o_frame && tick |=> !o_frame)
    else $error("frame strobe longer than one serial clock");
  a_both_words: assert property (
    ser_push && !start |-> !u_slot_i.active && !u_slot_q.active)
    else $error("serial pair pushed before both words");
  a_zero_empty: assert property (
    i_filt_req && !loc_valid && !par_push && !ser_push
    ##1 1 |-> o_filt_valid && o_filt_i == '0 && o_filt_q == '0)
    else $error("empty location did not feed zeros");
  a_loc_read: assert property (
    i_rd && i_addr == bbi_pkg::ADDR_I_DATA |=> o_rd_data == $past(loc_i))
    else $error("first location read back wrong");
  a_master_sclk: assert property (
    (sclk_sel == bbi_pkg::SCLK_MASTER)[*3] |-> o_sclk != $past(o_sclk))
    else $error("master rate serial clock not toggling");

  c_par_push: cover property (par_push ##1 o_push);
  c_ser_push: cover property (o_frame ##[1:1000] (o_push && serial_mode));
  c_zero_feed: cover property (i_filt_req && !loc_valid);
endmodule

// *** hw/bbi_pkg.sv ***
// constants shared by the baseband sample input stage
package bbi_pkg;
  // -----------------------------------------------------------------
  // register offsets
  // -----------------------------------------------------------------
  localparam logic [6:0] ADDR_I_DATA   = 7'h00;
  localparam logic [6:0] ADDR_Q_DATA   = 7'h01;
  localparam logic [6:0] ADDR_MAIN_CTL = 7'h0c;
  localparam logic [6:0] ADDR_SER_CTL  = 7'h11;
  localparam logic [6:0] ADDR_I_SLOT   = 7'h12;
  localparam logic [6:0] ADDR_Q_SLOT   = 7'h13;
  localparam logic [6:0] ADDR_SER_AUX  = 7'h17;
  // -----------------------------------------------------------------
  // field positions
  // -----------------------------------------------------------------
  localparam int MAIN_SW_TXEN   = 0;
  localparam int MAIN_TXEN_INDEP = 3;
  localparam int SER_MODE_BIT   = 15;
  localparam int SER_CLK_LSB    = 8;
  localparam int SER_LEN_LSB    = 2;
  localparam int SER_PORT_LSB   = 0;
  localparam int AUX_B2B_LSB    = 13;
  // -----------------------------------------------------------------
  // codes and reset values
  // -----------------------------------------------------------------
  localparam logic [5:0]  SCLK_MASTER  = 6'h00;
  localparam logic [5:0]  SCLK_32X     = 6'h3f;
  localparam logic [15:0] MIN_SCLK_PER = 16'h0002;
  localparam int          X32_SHIFT    = 5;
  localparam logic [15:0] CTL_RESET    = 16'h0000;
  localparam logic [9:0]  SLOT_RESET   = 10'h000;
endpackage

// *** hw/bbi_slot.sv ***
// one time-slot counter with its serial-to-parallel shifter
`timescale 1ns/1ps
module bbi_slot #(
  parameter int SLOT_W = 10,
  parameter int WORD_W = 16
) (
  // clock and reset
  input  wire logic              i_ref_clk,
  input  wire logic              i_rst,
  // serial timing
  input  wire logic              i_tick,
  input  wire logic              i_start,
  input  wire logic [SLOT_W-1:0] i_slot,
  input  wire logic [1:0]        i_len_code,
  input  wire logic              i_bit,
  // captured word
  output logic                   o_done,
  output logic [WORD_W-1:0]      o_word
);
  logic              active;
  logic [SLOT_W-1:0] cnt;
  logic [WORD_W-1:0] shift;
  logic              next_active;
  logic [SLOT_W-1:0] next_cnt;
  logic [WORD_W-1:0] next_shift;
  logic              next_done;
  logic [WORD_W-1:0] next_word;
  logic [SLOT_W:0]   len;
  logic [SLOT_W-1:0] c;

  always_comb begin
    next_active = active;
    next_cnt    = cnt;
    next_shift  = shift;
    next_done   = 1'b0;
    next_word   = o_word;
    len         = (SLOT_W+1)'({i_len_code, 2'b00}) + (SLOT_W+1)'(4);
    c           = cnt + SLOT_W'(1);
    if (i_start) begin
      next_active = 1'b1;
      next_cnt    = '0;
      next_shift  = '0;
    end else if (i_tick && active) begin
      next_cnt = c;
      // bits inside the window (slot-len, slot] belong to this word
      if (({1'b0, c} + len) > {1'b0, i_slot}) begin
        next_shift = {shift[WORD_W-2:0], i_bit};
      end
      if (c == i_slot) begin
        next_active = 1'b0;
        next_done   = 1'b1;
        // left justify the received word to the msb
        next_word   = {shift[WORD_W-2:0], i_bit}
                      << (WORD_W'(12) - WORD_W'({i_len_code, 2'b00}));
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      active <= 1'b0;
      cnt    <= '0;
      shift  <= '0;
      o_done <= 1'b0;
      o_word <= '0;
    end else begin
      active <= next_active;
      cnt    <= next_cnt;
      shift  <= next_shift;
      o_done <= next_done;
      o_word <= next_word;
    end
  end
endmodule

// *** verification/bbi_src_model.sv ***
// behavioural serial sample source facing the channel's six-wire port
`timescale 1ns/1ps
module bbi_src_model (
  // serial link from the channel
  input  wire logic        i_sclk,
  input  wire logic        i_frame,
  // source setup
  input  wire logic [1:0]  i_port_sel,
  input  wire logic [1:0]  i_len_code,
  input  wire logic [9:0]  i_slot_i,
  input  wire logic [9:0]  i_slot_q,
  input  wire logic [15:0] i_word_i,
  input  wire logic [15:0] i_word_q,
  // four data lines
  output logic [3:0]       o_ser_data = 4'h0
);
  // -----------------------------------------------------------------
  // slot tracking and bit launch
  // -----------------------------------------------------------------
  int   cnt = 0;
  int   len;
  int   pos_i;
  int   pos_q;
  logic bit_q = 1'b0;

  // counting at the fall keeps the frame read clear of the channel's
  // own update; the frame period is count zero, each later period adds one
  // launch on the falling edge so the bit is steady at the next rise
  always @(negedge i_sclk) begin
    if (i_frame) begin
      cnt = 0;
    end else begin
      cnt = cnt + 1;
    end
    len   = 4 * (int'(i_len_code) + 1);
    pos_i = cnt + len - int'(i_slot_i);
    pos_q = cnt + len - int'(i_slot_q);
    if (pos_i >= 0 && pos_i < len) begin
      bit_q = i_word_i[15-pos_i];
    end else if (pos_q >= 0 && pos_q < len) begin
      bit_q = i_word_q[15-pos_q];
    end else begin
      // released line: toggle so a stale sample never looks right
      bit_q = ~bit_q;
    end
    // unselected lines carry the inverse, so a wrong pick shows up
    o_ser_data <= ~{4{bit_q}} ^ (4'h1 << i_port_sel);
  end
endmodule

// *** verification/tb_bbi_input.sv ***
// self-checking bench for the baseband sample input stage
`timescale 1ns/1ps
module tb_bbi_input;
  logic        i_ref_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic [6:0]  i_addr = 7'h00;
  logic [15:0] i_wr_data = 16'h0000;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic        i_sample_start = 1'b0;
  logic        i_transmit_enable_pin = 1'b0;
  logic        i_filt_req = 1'b0;
  logic [3:0]  i_ser_data;
  logic [15:0] o_rd_data;
  logic        o_sclk;
  logic        o_frame;
  logic        o_push;
  logic [15:0] o_push_i;
  logic [15:0] o_push_q;
  logic        o_filt_valid;
  logic [15:0] o_filt_i;
  logic [15:0] o_filt_q;
  logic [15:0] m_ctl = 16'h0000;
  logic [9:0]  m_si = 10'h000;
  logic [9:0]  m_sq = 10'h000;
  logic [15:0] m_wi = 16'h0000;
  logic [15:0] m_wq = 16'h0000;
  logic        m_sync = 1'b0;
  int          error_cnt = 0;
  int          n_tests = 0;

  always #5 i_ref_clk = ~i_ref_clk;

  bbi_input #(.WORD_W(16), .SLOT_W(10)) u_dut (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd),
    .o_rd_data(o_rd_data), .i_sample_start(i_sample_start),
    .i_transmit_enable_pin(i_transmit_enable_pin),
    .i_ser_data(i_ser_data), .o_sclk(o_sclk), .o_frame(o_frame),
    .o_push(o_push), .o_push_i(o_push_i), .o_push_q(o_push_q),
    .i_filt_req(i_filt_req), .o_filt_valid(o_filt_valid),
    .o_filt_i(o_filt_i), .o_filt_q(o_filt_q)
  );

  bbi_src_model u_src (
    .i_sclk(o_sclk), .i_frame(o_frame | m_sync), .i_port_sel(m_ctl[1:0]),
    .i_len_code(m_ctl[3:2]), .i_slot_i(m_si), .i_slot_q(m_sq),
    .i_word_i(m_wi), .i_word_q(m_wq), .o_ser_data(i_ser_data)
  );

  // -----------------------------------------------------------------
  // compare, bus and closing tasks
  // -----------------------------------------------------------------
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_n(input int got, input int exp);
    n_tests++;
    if (got != exp) begin
      error_cnt++;
      $display("wrong value at %0t: count %0d expected %0d", $time, got,
               exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge i_ref_clk);
    i_wr      <= 1'b1;
    i_addr    <= a;
    i_wr_data <= d;
    @(posedge i_ref_clk);
    i_wr      <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [6:0] a, input logic [15:0] exp);
    @(posedge i_ref_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd   <= 1'b0;
    #1;
    chk16(o_rd_data, exp);
  endtask

  task automatic filt(input logic [15:0] ei, input logic [15:0] eq);
    @(posedge i_ref_clk);
    i_filt_req <= 1'b1;
    @(posedge i_ref_clk);
    i_filt_req <= 1'b0;
    #1;
    chk16({15'h0000, o_filt_valid}, 16'h0001);
    chk16(o_filt_i, ei);
    chk16(o_filt_q, eq);
  endtask

  // one serial transfer: counts frame cycles and checks the push
  task automatic ser_run(input logic [15:0] ctl, input logic [15:0] mc,
                         input logic pin, input logic [9:0] si,
                         input logic [9:0] sq, input logic [15:0] wi,
                         input logic [15:0] wq, input logic exp_push,
                         input logic [15:0] ei, input logic [15:0] eq,
                         input int exp_fr);
    int   fr;
    int   k;
    logic seen;
    int   sy;
    logic prev;
    fr   = 0;
    sy   = 0;
    seen = 1'b0;
    @(posedge i_ref_clk);
    m_ctl <= ctl;
    m_si  <= si;
    m_sq  <= sq;
    m_wi  <= wi;
    m_wq  <= wq;
    i_transmit_enable_pin <= pin;
    wr(bbi_pkg::ADDR_MAIN_CTL, mc);
    wr(bbi_pkg::ADDR_I_SLOT, {6'h00, si});
    wr(bbi_pkg::ADDR_Q_SLOT, {6'h00, sq});
    wr(bbi_pkg::ADDR_SER_CTL, ctl);
    @(posedge i_ref_clk);
    i_sample_start <= 1'b1;
    @(posedge i_ref_clk);
    i_sample_start <= 1'b0;
    #1;
    prev = o_sclk;
    for (k = 0; k < 600; k++) begin
      @(posedge i_ref_clk);
      #1;
      if (o_frame === 1'b1) fr++;
      // a gated frame leaves the source blind: mark the slot start for it
      if (exp_fr == 0 && sy < 2 && o_sclk === 1'b1 && prev === 1'b0) begin
        m_sync = (sy == 0);
        sy++;
      end
      prev = o_sclk;
      if (o_push === 1'b1 && !seen) begin
        seen = 1'b1;
        chk16(o_push_i, ei);
        chk16(o_push_q, eq);
      end
    end
    chk16({15'h0000, seen}, {15'h0000, exp_push});
    chk_n(fr, exp_fr);
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // -----------------------------------------------------------------
  // watchdog: the tests need well under 8000 cycles
  // -----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge i_ref_clk);
    error_cnt++;
    $display("wrong value at %0t: watchdog expired", $time);
    wrap_up();
  end

  // -----------------------------------------------------------------
  // test sequence
  // -----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    rd(bbi_pkg::ADDR_SER_CTL, 16'h0000);
    rd(bbi_pkg::ADDR_I_SLOT, 16'h0000);
    rd(7'h05, 16'h0000);
    done("reset");
    wr(bbi_pkg::ADDR_Q_DATA, 16'h1234);
    wr(bbi_pkg::ADDR_I_DATA, 16'habcd);
    #1;
    chk16({15'h0000, o_push}, 16'h0001);
    chk16(o_push_i, 16'habcd);
    chk16(o_push_q, 16'h1234);
    @(posedge i_ref_clk);
    #1;
    chk16({15'h0000, o_push}, 16'h0000);
    rd(bbi_pkg::ADDR_I_DATA, 16'habcd);
    rd(bbi_pkg::ADDR_Q_DATA, 16'h1234);
    wr(bbi_pkg::ADDR_SER_AUX, 16'h6000);
    rd(bbi_pkg::ADDR_SER_AUX, 16'h6000);
    done("parallel");
    filt(16'habcd, 16'h1234);
    filt(16'h0000, 16'h0000);
    done("filter");
    // 16-bit words on line 2, master-rate clock, pin enable
    ser_run(16'h800e, 16'h0000, 1'b1, 10'd16, 10'd32, 16'ha5c3,
            16'h3c5a, 1'b1, 16'ha5c3, 16'h3c5a, 2);
    // 4-bit words, Q slot first, divided clock, line 1
    ser_run(16'h8201, 16'h0000, 1'b1, 10'd8, 10'd4, 16'h9fff,
            16'h6abc, 1'b1, 16'h9000, 16'h6000, 4);
    // 8-bit words on line 3 with the software enable alone
    ser_run(16'h8007, 16'h0001, 1'b0, 10'd12, 10'd24, 16'hc3ff,
            16'h5aff, 1'b1, 16'hc300, 16'h5a00, 2);
    done("serial");
    wr(bbi_pkg::ADDR_I_DATA, 16'h7777);
    #1;
    chk16({15'h0000, o_push}, 16'h0000);
    // no enable at all: no frame and no push
    ser_run(16'h800e, 16'h0000, 1'b0, 10'd16, 10'd32, 16'h1111,
            16'h2222, 1'b0, 16'h0000, 16'h0000, 0);
    // independent of enable: transfer runs with the frame pin gated
    ser_run(16'h800e, 16'h0008, 1'b0, 10'd16, 10'd32, 16'h1357,
            16'h2468, 1'b1, 16'h1357, 16'h2468, 0);
    done("enable");
    wrap_up();
  end
endmodule
